// *** core/lcdhp_consts.vh ***
`ifndef LCDHP_CONSTS_VH
`define LCDHP_CONSTS_VH
// apb register byte offsets
`define LCDHP_OFF_CTRL 12'h000
`define LCDHP_OFF_STAT 12'h004
`define LCDHP_OFF_INSTR 12'h008
`define LCDHP_OFF_WDATA 12'h00c
`define LCDHP_OFF_RDATA 12'h010
`define LCDHP_OFF_PTR 12'h014
// ctrl fields
`define LCDHP_CTRL_NIBBLE 0
`define LCDHP_CTRL_BUSY 1
`define LCDHP_CTRL_SERIAL 2
`define LCDHP_CTRL_RST 32'h0000_0000
// status fields
`define LCDHP_ST_INSTR_NEW 0
`define LCDHP_ST_DATA_NEW 1
`define LCDHP_ST_HALF 2
`define LCDHP_ST_SUBADDR 3
`define LCDHP_ST_SERIAL_BAD 4
// serial base address bits above the sub-address
`define LCDHP_SER_BASE 6'b011101
// idle levels of the host pins and the released data bus
`define LCDHP_PIN_IDLE 1'b1
`define LCDHP_STROBE_IDLE 1'b0
`define LCDHP_SUB_IDLE 1'b0
`define LCDHP_BUS_IDLE 8'hff
`endif

// *** core/lcdhp_port.v ***
`timescale 1ns/10ps
`include "lcdhp_consts.vh"
module lcdhp_port (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire reg_select,
  input wire rw_read,
  input wire strobe,
  input wire [7:0] host_data_in,
  output reg [7:0] host_data_out,
  output reg [7:0] host_data_oe,
  input wire serial_subaddr_pin,
  output reg [6:0] serial_addr,
  input wire factory_test_pad
);

  // ************************************************
  // pin synchronisers
  // ************************************************
  wire rs_f;
  wire rw_f;
  wire e_f;
  wire e_new;
  wire sa_f;
  wire [7:0] db_f;

  // register select and direction idle high like their pull-ups
  lcdhp_sync #(.W(1), .IDLE(`LCDHP_PIN_IDLE)) i_sync_rs (
    .clk(pclk),
    .rst_n(presetn),
    .pin(reg_select),
    .level_q(rs_f),
    .level_d()
  );
  lcdhp_sync #(.W(1), .IDLE(`LCDHP_PIN_IDLE)) i_sync_rw (
    .clk(pclk),
    .rst_n(presetn),
    .pin(rw_read),
    .level_q(rw_f),
    .level_d()
  );

  // strobe: the next level feeds the edge detectors
  lcdhp_sync #(.W(1), .IDLE(`LCDHP_STROBE_IDLE)) i_sync_e (
    .clk(pclk),
    .rst_n(presetn),
    .pin(strobe),
    .level_q(e_f),
    .level_d(e_new)
  );

  // sub-address pin
  lcdhp_sync #(.W(1), .IDLE(`LCDHP_SUB_IDLE)) i_sync_sa (
    .clk(pclk),
    .rst_n(presetn),
    .pin(serial_subaddr_pin),
    .level_q(sa_f),
    .level_d()
  );

  // data lines, seen high while released
  lcdhp_sync #(.W(8), .IDLE(`LCDHP_BUS_IDLE)) i_sync_db (
    .clk(pclk),
    .rst_n(presetn),
    .pin(host_data_in),
    .level_q(db_f),
    .level_d()
  );

  wire e_fall;
  assign e_fall = e_f & ~e_new;
  wire e_rise;
  assign e_rise = ~e_f & e_new;

  // ************************************************
  // registers
  // ************************************************
  // control reset value, only the low three bits exist
  localparam [31:0] CTRL_RST_W = `LCDHP_CTRL_RST;
  reg [2:0] ctrl_q;
  reg [7:0] instr_q;
  reg [7:0] wdata_q;
  reg [7:0] rdata_q;
  reg [6:0] ptr_q;
  reg instr_new_q;
  reg data_new_q;
  reg half_q;
  reg ser_bad_q;
  reg [7:0] acc_q;
  reg rd_cyc_q;
  reg rd_rs_q;

  wire nib_mode;
  assign nib_mode = ctrl_q[`LCDHP_CTRL_NIBBLE];
  wire busy;
  assign busy = ctrl_q[`LCDHP_CTRL_BUSY];
  wire ser_mode;
  assign ser_mode = ctrl_q[`LCDHP_CTRL_SERIAL];

  wire acc_phase;
  assign acc_phase = psel & penable;
  wire wr_en;
  assign wr_en = acc_phase & pwrite & pready;
  wire rd_en;
  assign rd_en = acc_phase & ~pwrite & pready;
  wire addr_ok;
  assign addr_ok = (paddr == `LCDHP_OFF_CTRL) | (paddr == `LCDHP_OFF_STAT) |
                   (paddr == `LCDHP_OFF_INSTR) | (paddr == `LCDHP_OFF_WDATA) |
                   (paddr == `LCDHP_OFF_RDATA) | (paddr == `LCDHP_OFF_PTR);

  // status byte: busy on bit 7, pointer on bits 6..0
  wire [7:0] status_byte;
  assign status_byte = {busy, ptr_q};
  wire [7:0] read_byte;
  assign read_byte = rd_rs_q ? rdata_q : status_byte;
  // status word assembled from its field positions
  reg [31:0] stat_word;
  always @* begin
    stat_word = 32'h0000_0000;
    stat_word[`LCDHP_ST_INSTR_NEW] = instr_new_q;
    stat_word[`LCDHP_ST_DATA_NEW] = data_new_q;
    stat_word[`LCDHP_ST_HALF] = half_q;
    stat_word[`LCDHP_ST_SUBADDR] = sa_f;
    stat_word[`LCDHP_ST_SERIAL_BAD] = ser_bad_q;
  end

  // one byte per strobe, or two nibbles in 4-bit mode
  wire byte_done;
  assign byte_done = e_fall & ~ser_mode & (~nib_mode | half_q);
  wire [7:0] byte_in;
  assign byte_in = nib_mode ? {acc_q[7:4], db_f[7:4]} : db_f;

  // host-side transfers and software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST_W[2:0];
      instr_q <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      ptr_q <= 7'h00;
      instr_new_q <= 1'b0;
      data_new_q <= 1'b0;
      half_q <= 1'b0;
      ser_bad_q <= 1'b0;
      acc_q <= 8'h00;
      rd_cyc_q <= 1'b0;
      rd_rs_q <= 1'b0;
    end else begin
      // software side: clears first so hardware sets win
      if (wr_en && paddr == `LCDHP_OFF_CTRL) begin
        ctrl_q <= pwdata[2:0];
        half_q <= 1'b0;
      end
      if (wr_en && paddr == `LCDHP_OFF_RDATA) rdata_q <= pwdata[7:0];
      if (wr_en && paddr == `LCDHP_OFF_PTR) ptr_q <= pwdata[6:0];
      if (wr_en && paddr == `LCDHP_OFF_STAT) begin
        if (pwdata[`LCDHP_ST_INSTR_NEW]) instr_new_q <= 1'b0;
        if (pwdata[`LCDHP_ST_DATA_NEW]) data_new_q <= 1'b0;
        if (pwdata[`LCDHP_ST_SERIAL_BAD]) ser_bad_q <= 1'b0;
      end
      // strobe activity while in serial mode is flagged
      if (ser_mode && e_rise) ser_bad_q <= 1'b1;
      // latch the cycle type at strobe rise
      if (e_rise && !ser_mode) begin
        rd_cyc_q <= rw_f;
        rd_rs_q <= rs_f;
      end
      if (e_fall && !ser_mode) begin
        if (nib_mode) half_q <= ~half_q;
        if (nib_mode && !half_q) acc_q <= {db_f[7:4], 4'h0};
        rd_cyc_q <= 1'b0;
      end
      if (byte_done && !rd_cyc_q) begin
        if (!rd_rs_q) begin
          // instructions refused while busy
          if (!busy) begin
            instr_q <= byte_in;
            instr_new_q <= 1'b1;
          end
        end else begin
          wdata_q <= byte_in;
          data_new_q <= 1'b1;
        end
      end
    end
  end

  // ************************************************
  // data bus drive
  // ************************************************
  // drive only in read cycles, upper lines in 4-bit mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_data_out <= 8'hff;
      host_data_oe <= 8'h00;
    end else begin
      if (rd_cyc_q && !ser_mode) begin
        if (nib_mode) begin
          host_data_out <= {half_q ? read_byte[3:0] : read_byte[7:4], 4'hf};
          host_data_oe <= 8'hf0;
        end else begin
          host_data_out <= read_byte;
          host_data_oe <= 8'hff;
        end
      end else begin
        host_data_out <= 8'hff;
        host_data_oe <= 8'h00;
      end
    end
  end

  // ************************************************
  // serial address and apb slave
  // ************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_addr <= {`LCDHP_SER_BASE, 1'b0};
    end else begin
      serial_addr <= {`LCDHP_SER_BASE, sa_f};
    end
  end

  // one wait state: pready on the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc_phase & ~pready;
      pslverr <= acc_phase & ~pready & ~addr_ok;
      if (acc_phase && !pready && !pwrite) begin
        case (paddr)
          `LCDHP_OFF_CTRL: prdata <= {29'h0, ctrl_q};
          `LCDHP_OFF_STAT: prdata <= stat_word;
          `LCDHP_OFF_INSTR: prdata <= {24'h0, instr_q};
          `LCDHP_OFF_WDATA: prdata <= {24'h0, wdata_q};
          `LCDHP_OFF_RDATA: prdata <= {24'h0, rdata_q};
          `LCDHP_OFF_PTR: prdata <= {25'h0, ptr_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  wire unused_ok;
  assign unused_ok = factory_test_pad | rd_en;

endmodule

// ************************************************
// pin synchroniser
// ************************************************
// three stages; a change counts once stages 2 and 3 agree
module lcdhp_sync #(
  parameter W = 1,
  parameter [W-1:0] IDLE = {W{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] pin,
  output reg [W-1:0] level_q,
  output wire [W-1:0] level_d
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  // stage 1 feeds stage 2 only, so no logic sees a metastable bit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= IDLE;
      s2_q <= IDLE;
      s3_q <= IDLE;
      level_q <= IDLE;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

  // old level is kept while the stages disagree
  assign level_d = (s2_q == s3_q) ? s3_q : level_q;
endmodule

// *** tb/lcdhp_checker.sv ***
`timescale 1ns/10ps
// ****************
// port checker
// ****************
module lcdhp_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire rw_read,
  input wire strobe,
  input wire [7:0] host_data_out,
  input wire [7:0] host_data_oe,
  input wire serial_subaddr_pin,
  input wire [6:0] serial_addr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb handshake, one wait state
  a_wait_one: assert property (psel && penable && !pready |=> pready) else $error("wait state length");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_err_unmap: assert property (pready && paddr > 12'h014 |-> pslverr) else $error("no error on unmapped");
  a_ok_mapped: assert property (pready && paddr <= 12'h014 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error on mapped");
  // data bus direction and release
  a_oe_read: assert property (host_data_oe != 8'h00 |-> rw_read)
    else $error("bus driven in write");
  a_oe_release: assert property ($fell(strobe) |-> ##[1:8] host_data_oe == 8'h00)
    else $error("bus not released");
  a_oe_lanes: assert property (host_data_oe == 8'h00 || host_data_oe == 8'hf0 || host_data_oe == 8'hff)
    else $error("odd lane enable");
  a_out_idle: assert property (host_data_oe == 8'h00 |-> host_data_out == 8'hff)
    else $error("idle output not high");
  // serial sub-address
  a_sub_base: assert property (serial_addr[6:1] == 6'b01_1101)
    else $error("serial base wrong");
  a_sub_pin: assert property ($stable(serial_subaddr_pin)[*8] |-> serial_addr[0] == serial_subaddr_pin)
    else $error("sub-address bit stale");
  c_err: cover property (pready && pslverr);
  c_rd8: cover property (host_data_oe == 8'hff);
  c_rd4: cover property (host_data_oe == 8'hf0);
endmodule
bind lcdhp_port lcdhp_checker i_chk (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .rw_read,
  .strobe, .host_data_out, .host_data_oe, .serial_subaddr_pin, .serial_addr);

// *** tb/lcdhp_host_model.sv ***
`timescale 1ns/10ps
// ****************
// host controller model
// ****************
module lcdhp_host_model (
  input wire pclk,
  input wire [7:0] host_data_out,
  input wire [7:0] host_data_oe,
  output wire [7:0] host_data_in,
  output reg reg_select = 1'b1,
  output reg rw_read = 1'b1,
  output reg strobe = 1'b0
);
  reg [7:0] drv = 8'hff;
  reg [7:0] hoe = 8'h00;
  // bus level: device, else host, else pull-up
  assign host_data_in = (host_data_oe & host_data_out) | (~host_data_oe & hoe & drv) | (~host_data_oe & ~hoe);
  // one strobe cycle, phases of 10 to 12 clocks
  task cyc(input r, input w, input [7:0] d, input [7:0] m, output [7:0] q);
    begin
      @(posedge pclk);
      reg_select <= r;
      rw_read <= w;
      drv <= d;
      hoe <= w ? 8'h00 : m;
      repeat (10) @(posedge pclk);
      strobe <= 1'b1;
      repeat (12) @(posedge pclk);
      q = host_data_in;
      strobe <= 1'b0;
      repeat (12) @(posedge pclk);
      hoe <= 8'h00;
      rw_read <= 1'b1;
    end
  endtask
  // one byte, as two nibbles on lines 7..4 in 4-bit mode
  task xfer(input r, input w, input four, input [7:0] d, output [7:0] q);
    reg [7:0] hi, lo;
    begin
      if (four) begin
        cyc(r, w, {d[7:4], 4'h0}, 8'hf0, hi);
        cyc(r, w, {d[3:0], 4'h0}, 8'hf0, lo);
        q = {hi[7:4], lo[7:4]};
      end else
        cyc(r, w, d, 8'hff, q);
    end
  endtask
endmodule

// *** tb/tb_lcd_ctrl_host_bus_port.sv ***
`timescale 1ns/10ps
`include "lcdhp_consts.vh"
// ****************
// bench top
// ****************
module tb_lcd_ctrl_host_bus_port;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg serial_subaddr_pin = 1'b1;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0000_0000;
  reg [31:0] rd;
  reg [7:0] q;
  reg err;
  integer err_count = 0;
  integer n_checks = 0;
  wire [31:0] prdata;
  wire pready, pslverr, reg_select, rw_read, strobe;
  wire [7:0] host_data_in, host_data_out, host_data_oe;
  wire [6:0] serial_addr;
  always #12.5 pclk = ~pclk;
  lcdhp_port i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .reg_select, .rw_read, .strobe, .host_data_in, .host_data_out, .host_data_oe, .serial_subaddr_pin,
    .serial_addr, .factory_test_pad(1'b0));
  lcdhp_host_model i_host (.pclk, .host_data_out, .host_data_oe, .host_data_in, .reg_select, .rw_read, .strobe);
  // apb transfer, held until pready
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rdchk(input [11:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, e);
    end
  endtask
  task report_and_stop;
    begin
      if (err_count == 0 && n_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({25'h0, serial_addr}, 32'h0000_003b);
    rdchk(`LCDHP_OFF_CTRL, 32'h0000_0000);
    i_host.xfer(1'b0, 1'b0, 1'b0, 8'ha5, q);
    rdchk(`LCDHP_OFF_INSTR, 32'h0000_00a5);
    i_host.xfer(1'b1, 1'b0, 1'b0, 8'h5a, q);
    rdchk(`LCDHP_OFF_WDATA, 32'h0000_005a);
    apb(1'b1, `LCDHP_OFF_RDATA, 32'h0000_003c);
    i_host.xfer(1'b1, 1'b1, 1'b0, 8'h00, q);
    chk({24'h00_0000, q}, 32'h0000_003c);
    apb(1'b1, `LCDHP_OFF_PTR, 32'h0000_002b);
    apb(1'b1, `LCDHP_OFF_CTRL, 32'h0000_0002);
    i_host.xfer(1'b0, 1'b1, 1'b0, 8'h00, q);
    chk({24'h00_0000, q}, 32'h0000_00ab);
    i_host.xfer(1'b0, 1'b0, 1'b0, 8'h11, q);
    rdchk(`LCDHP_OFF_INSTR, 32'h0000_00a5);
    apb(1'b1, `LCDHP_OFF_CTRL, 32'h0000_0001);
    i_host.xfer(1'b0, 1'b0, 1'b1, 8'hc3, q);
    rdchk(`LCDHP_OFF_INSTR, 32'h0000_00c3);
    i_host.xfer(1'b0, 1'b1, 1'b1, 8'h00, q);
    chk({24'h00_0000, q}, 32'h0000_002b);
    apb(1'b1, `LCDHP_OFF_STAT, 32'h0000_0013);
    apb(1'b1, `LCDHP_OFF_CTRL, 32'h0000_0004);
    i_host.xfer(1'b0, 1'b0, 1'b0, 8'h77, q);
    rdchk(`LCDHP_OFF_STAT, 32'h0000_0018);
    rdchk(`LCDHP_OFF_INSTR, 32'h0000_00c3);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    // mid-run reset: address bit falls back to zero though the pin is high
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({25'h0, serial_addr}, 32'h0000_003a);
    presetn <= 1'b1;
    rdchk(`LCDHP_OFF_CTRL, 32'h0000_0000);
    rdchk(`LCDHP_OFF_INSTR, 32'h0000_0000);
    serial_subaddr_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({25'h0, serial_addr}, 32'h0000_003a);
    report_and_stop;
  end
  // watchdog
  initial begin
    #100000;
    err_count = err_count + 1;
    report_and_stop;
  end
endmodule
